// ---- src/ctpc_pkg.sv ----
// package: register map, field positions, reset values and delay sequencer states
package ctpc_pkg;
    // =======================================================
    // register offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] EDGE_OFFSET = 4'h1;
    localparam logic [3:0] STATUS_OFFSET = 4'h2;
    // =======================================================
    // control register fields
    localparam int MODULE_ENABLE_BIT = 0;
    localparam int IDLE_STOP_BIT = 1;
    localparam int DELAY_GEN_ENABLE_BIT = 2;
    localparam int DELAY_SOURCE_SELECT_BIT = 3;
    localparam int DISCHARGE_CONTROL_BIT = 4;
    // edge register fields
    localparam int FIRST_EDGE_BIT = 0;
    localparam int SECOND_EDGE_BIT = 1;
    // status register fields
    localparam int SOURCE_ON_BIT = 0;
    localparam int PULSE_BIT = 1;
    localparam int DELAY_DONE_BIT = 2;
    // =======================================================
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] EDGE_RESET = 8'h00;
    // =======================================================
    // delay sequencer states
    typedef enum logic [2:0] {
        DLY_IDLE = 3'b001,
        DLY_CHARGE = 3'b010,
        DLY_DONE = 3'b100
    } ctpc_dly_e;
endpackage : ctpc_pkg

// ---- src/ctpc_sync2.sv ----
// two-stage synchroniser for one asynchronous level
`timescale 1ns/1ns
module ctpc_sync2 (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic async,
    output logic synced
);
    logic stage1;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            synced <= 1'b0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule : ctpc_sync2

// ---- src/ctpc_core.sv ----
// charge-time pulse control: current source gating and delay pulse
// =======================================================
`timescale 1ns/1ns
module ctpc_core
    import ctpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic sleepMode,
    input wire logic idleMode,
    input wire logic comparatorOut,
    input wire logic delay_trigger_in,
    output logic currentSourceOn,
    output logic dischargeOn,
    output logic pulse_out
);
    // =======================================================
    // registers
    logic [7:0] ctrl;
    logic [7:0] edges;
    ctpc_dly_e dlyState;
    ctpc_dly_e next_dlyState;
    logic compSync;
    logic trigSync;

    // comparator and trigger pins are asynchronous to ref_clk
    ctpc_sync2 u_comp_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async(comparatorOut),
        .synced(compSync)
    );
    ctpc_sync2 u_trig_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async(delay_trigger_in),
        .synced(trigSync)
    );

    // =======================================================
    // decode
    wire moduleEnable = ctrl[MODULE_ENABLE_BIT];
    wire idleStop = ctrl[IDLE_STOP_BIT];
    wire delayGenEnable = ctrl[DELAY_GEN_ENABLE_BIT];
    wire delaySourceSelect = ctrl[DELAY_SOURCE_SELECT_BIT];
    wire firstEdgeStatus = edges[FIRST_EDGE_BIT];
    wire secondEdgeStatus = edges[SECOND_EDGE_BIT];
    wire ctrlWrite = regWrite && (regAddr == CTRL_OFFSET);
    wire edgeWrite = regWrite && (regAddr == EDGE_OFFSET);
    wire powerBlock = sleepMode || (idleMode && idleStop);
    // the delay end event stops charging, as if a second edge arrived
    wire delayEnd = delaySourceSelect ? trigSync : compSync;
    wire chargeAllowed = moduleEnable && firstEdgeStatus
        && !secondEdgeStatus && !powerBlock;
    wire next_sourceOn = chargeAllowed
        && !(delayGenEnable && dlyState == DLY_DONE);
    wire next_pulse = delayGenEnable && moduleEnable
        && (dlyState == DLY_DONE);
    wire [7:0] statusWord = {5'h00, dlyState == DLY_DONE, pulse_out,
        currentSourceOn};
    wire [7:0] next_rdData = !regRead ? 8'h00 :
        (regAddr == CTRL_OFFSET) ? ctrl :
        (regAddr == EDGE_OFFSET) ? edges :
        (regAddr == STATUS_OFFSET) ? statusWord : 8'h00;

    // =======================================================
    // delay sequencer: waits on the analog event, never on a count
    always_comb begin
        next_dlyState = dlyState;
        case (dlyState)
            DLY_IDLE: begin
                if (delayGenEnable && chargeAllowed)
                    next_dlyState = DLY_CHARGE;
            end
            DLY_CHARGE: begin
                if (!delayGenEnable || !firstEdgeStatus || !moduleEnable)
                    next_dlyState = DLY_IDLE;
                else if (delayEnd)
                    next_dlyState = DLY_DONE;
            end
            DLY_DONE: begin
                // pulse holds until software drops first edge, the delay mode or the module enable
                if (!delayGenEnable || !firstEdgeStatus || !moduleEnable)
                    next_dlyState = DLY_IDLE;
            end
            default: next_dlyState = DLY_IDLE;
        endcase
    end

    // =======================================================
    // register file and outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            edges <= EDGE_RESET;
            dlyState <= DLY_IDLE;
            currentSourceOn <= 1'b0;
            dischargeOn <= 1'b0;
            pulse_out <= 1'b0;
            regRdData <= 8'h00;
        end else begin
            if (ctrlWrite)
                ctrl <= {3'h0, regWrData[4:0]};
            if (edgeWrite)
                edges <= {6'h00, regWrData[1:0]};
            dlyState <= next_dlyState;
            currentSourceOn <= next_sourceOn;
            dischargeOn <= ctrl[DISCHARGE_CONTROL_BIT] && moduleEnable;
            pulse_out <= next_pulse;
            regRdData <= next_rdData;
        end
    end

    // =======================================================
    // checks
    chk_sleep_forces_off: assert property (@(posedge ref_clk)
        disable iff (reset) sleepMode |=> !currentSourceOn)
        else $error("current source on during sleep");
    chk_idle_stop_off: assert property (@(posedge ref_clk)
        disable iff (reset) (idleMode && idleStop) |=> !currentSourceOn)
        else $error("current source on in idle with idle stop");
    chk_charge_on_edge: assert property (@(posedge ref_clk)
        disable iff (reset)
        (moduleEnable && firstEdgeStatus && !secondEdgeStatus
         && !powerBlock && !delayGenEnable) |=> currentSourceOn)
        else $error("first edge set but source off");
    chk_second_edge_stop: assert property (@(posedge ref_clk)
        disable iff (reset) secondEdgeStatus |=> !currentSourceOn)
        else $error("charging after second edge");
    chk_source_equation: assert property (@(posedge ref_clk)
        disable iff (reset)
        currentSourceOn |-> $past(moduleEnable && firstEdgeStatus))
        else $error("source on without enable and first edge");
    chk_pulse_needs_mode: assert property (@(posedge ref_clk)
        disable iff (reset) pulse_out |-> $past(delayGenEnable))
        else $error("pulse outside delay mode");
    chk_comp_ends_delay: assert property (@(posedge ref_clk)
        disable iff (reset)
        (dlyState == DLY_CHARGE && !delaySourceSelect && compSync
         && delayGenEnable && firstEdgeStatus && moduleEnable)
        |=> ##1 pulse_out)
        else $error("comparator trip gave no pulse");
    chk_trig_ends_delay: assert property (@(posedge ref_clk)
        disable iff (reset)
        (dlyState == DLY_CHARGE && delaySourceSelect && trigSync
         && delayGenEnable && firstEdgeStatus && moduleEnable)
        |=> ##1 pulse_out)
        else $error("trigger gave no pulse");
    chk_source_select: assert property (@(posedge ref_clk)
        disable iff (reset)
        (dlyState == DLY_CHARGE && !delayEnd) |=> dlyState != DLY_DONE)
        else $error("delay ended by unselected source");
    chk_pulse_analog: assert property (@(posedge ref_clk)
        disable iff (reset)
        $rose(pulse_out) |-> $past(dlyState == DLY_DONE))
        else $error("pulse not caused by analog end event");
    chk_reset_clears: assert property (@(posedge ref_clk)
        $past(reset) |-> (ctrl == CTRL_RESET && edges == EDGE_RESET
        && !currentSourceOn))
        else $error("reset left control state");

    // =======================================================
    // further checks on gating, sequencing and the register port
    // the gating equation is restated from the rules, not from next_sourceOn
    chk_source_exact: assert property (@(posedge ref_clk)
        disable iff (reset)
        $past(!delayGenEnable) |-> currentSourceOn == $past(moduleEnable
        && firstEdgeStatus && !secondEdgeStatus && !sleepMode
        && !(idleMode && idleStop)))
        else $error("source differs from gating equation");

    chk_disable_stops: assert property (@(posedge ref_clk)
        disable iff (reset) !moduleEnable |=> !currentSourceOn)
        else $error("source on while unit disabled");

    chk_first_clear_stops: assert property (@(posedge ref_clk)
        disable iff (reset) !firstEdgeStatus |=> !currentSourceOn)
        else $error("source on after first edge cleared");

    chk_idle_run: assert property (@(posedge ref_clk)
        disable iff (reset)
        (idleMode && !idleStop && !sleepMode && moduleEnable
         && firstEdgeStatus && !secondEdgeStatus && !delayGenEnable)
        |=> currentSourceOn)
        else $error("idle without idle stop halted the source");

    chk_mode_off_no_pulse: assert property (@(posedge ref_clk)
        disable iff (reset) !delayGenEnable |=> !pulse_out)
        else $error("pulse with delay mode off");

    chk_enable_off_no_pulse: assert property (@(posedge ref_clk)
        disable iff (reset) !moduleEnable |=> !pulse_out)
        else $error("pulse with unit disabled");

    // the pulse may stand one more cycle while the state falls back
    chk_pulse_clears_first: assert property (@(posedge ref_clk)
        disable iff (reset) !firstEdgeStatus |-> ##2 !pulse_out)
        else $error("pulse kept after first edge cleared");

    chk_pulse_only_done: assert property (@(posedge ref_clk)
        disable iff (reset) pulse_out |-> $past(dlyState == DLY_DONE))
        else $error("pulse outside delay done state");

    chk_done_from_charge: assert property (@(posedge ref_clk)
        disable iff (reset)
        (dlyState == DLY_DONE) |-> ($past(dlyState) == DLY_CHARGE
        || $past(dlyState) == DLY_DONE))
        else $error("delay done without a charge phase");

    chk_done_needs_event: assert property (@(posedge ref_clk)
        disable iff (reset)
        (dlyState == DLY_DONE && $past(dlyState) == DLY_CHARGE)
        |-> $past(delaySourceSelect ? trigSync : compSync))
        else $error("delay ended without the selected event");

    chk_comp_ignored: assert property (@(posedge ref_clk)
        disable iff (reset)
        (dlyState == DLY_CHARGE && delaySourceSelect && !trigSync)
        |=> dlyState != DLY_DONE)
        else $error("comparator ended a trigger-sourced delay");

    chk_trig_ignored: assert property (@(posedge ref_clk)
        disable iff (reset)
        (dlyState == DLY_CHARGE && !delaySourceSelect && !compSync)
        |=> dlyState != DLY_DONE)
        else $error("trigger ended a comparator-sourced delay");

    // once the delay has ended the capacitor must not keep charging
    chk_source_off_done: assert property (@(posedge ref_clk)
        disable iff (reset)
        (delayGenEnable && dlyState == DLY_DONE) |=> !currentSourceOn)
        else $error("source still on after delay end");

    chk_state_onehot: assert property (@(posedge ref_clk)
        disable iff (reset) $onehot(dlyState))
        else $error("delay state not one-hot");

    chk_rd_idle_zero: assert property (@(posedge ref_clk)
        disable iff (reset) !regRead |=> regRdData == 8'h00)
        else $error("read data without a read strobe");

    chk_rd_ctrl: assert property (@(posedge ref_clk)
        disable iff (reset)
        (regRead && regAddr == CTRL_OFFSET) |=> regRdData == $past(ctrl))
        else $error("control read returned wrong data");

    chk_rd_edges: assert property (@(posedge ref_clk)
        disable iff (reset)
        (regRead && regAddr == EDGE_OFFSET) |=> regRdData == $past(edges))
        else $error("edge read returned wrong data");

    // unused bits must stay clear so software reads them as zero
    chk_unused_bits: assert property (@(posedge ref_clk)
        disable iff (reset)
        ctrl[7:5] == 3'h0 && edges[7:2] == 6'h00)
        else $error("unused register bits set");

    chk_discharge_level: assert property (@(posedge ref_clk)
        disable iff (reset) dischargeOn |-> $past(moduleEnable))
        else $error("discharge on with unit disabled");

    chk_reset_outputs: assert property (@(posedge ref_clk)
        $past(reset) |-> (!pulse_out && !dischargeOn
        && regRdData == 8'h00 && dlyState == DLY_IDLE))
        else $error("reset left outputs or sequencer state");
endmodule : ctpc_core

// ---- verification/ctpc_analog_model.sv ----
// far side model: delay capacitor charge and comparator 2
`timescale 1ns/1ns
module ctpc_analog_model #(
    parameter int TRIP = 12
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic currentSourceOn,
    input wire logic dischargeOn,
    output logic comparatorOut
);
    // =======================================================
    // capacitor
    // charge is held when the source stops, as a real capacitor does
    logic [7:0] charge;
    always_ff @(posedge ref_clk) begin
        if (reset || dischargeOn) begin
            charge <= 8'h00;
        end else if (currentSourceOn && charge != 8'hff) begin
            charge <= charge + 8'h01;
        end
    end
    assign comparatorOut = (charge >= 8'(TRIP));
endmodule : ctpc_analog_model

// ---- verification/tb.sv ----
// testbench: register sequences for the charge-time pulse control
`timescale 1ns/1ns
module tb;
    import ctpc_pkg::*;
    localparam int TRIP = 12;
    logic ref_clk, reset, regWrite, regRead, sleepMode, idleMode;
    logic delay_trigger_in, comparatorOut, currentSourceOn, dischargeOn;
    logic pulse_out;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData;
    int errTotal, comparisons, n;
    ctpc_core i_ctpc_core (.ref_clk(ref_clk), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .sleepMode(sleepMode),
        .idleMode(idleMode), .comparatorOut(comparatorOut),
        .delay_trigger_in(delay_trigger_in),
        .currentSourceOn(currentSourceOn), .dischargeOn(dischargeOn),
        .pulse_out(pulse_out));
    ctpc_analog_model #(.TRIP(TRIP)) i_ctpc_analog_model (.ref_clk(ref_clk),
        .reset(reset), .currentSourceOn(currentSourceOn),
        .dischargeOn(dischargeOn), .comparatorOut(comparatorOut));
    // =======================================================
    // tasks
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errTotal++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 check(regRdData, exp);
    endtask : rd
    task settle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : settle
    // bounded so a missing pulse cannot hang the run
    task wait_pulse;
        n = 0;
        while (pulse_out !== 1'b1 && n < 200) begin
            settle(1);
            n++;
        end
    endtask : wait_pulse
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        #100000;
        errTotal++;
        conclude;
    end
    // =======================================================
    // sequences
    initial begin
        {reset, regWrite, regRead, sleepMode, idleMode} = 5'b10000;
        {regAddr, regWrData, delay_trigger_in} = '0;
        {errTotal, comparisons} = '0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(CTRL_OFFSET, CTRL_RESET);
        rd(EDGE_OFFSET, EDGE_RESET);
        rd(STATUS_OFFSET, 8'h00);
        rd(4'hf, 8'h00);
        rd(CTRL_OFFSET, CTRL_RESET);
        settle(1);
        check(regRdData, 8'h00);
        wr(CTRL_OFFSET, 8'h01);
        wr(EDGE_OFFSET, 8'h01);
        settle(2);
        check(currentSourceOn, 8'h01);
        sleepMode <= 1'b1;
        settle(2);
        check(currentSourceOn, 8'h00);
        {sleepMode, idleMode} <= 2'b01;
        settle(2);
        check(currentSourceOn, 8'h01);
        wr(CTRL_OFFSET, 8'h03);
        settle(2);
        check(currentSourceOn, 8'h00);
        idleMode <= 1'b0;
        settle(2);
        check(currentSourceOn, 8'h01);
        wr(EDGE_OFFSET, 8'h03);
        settle(2);
        check(currentSourceOn, 8'h00);
        // trigger source: the comparator trips first and must be ignored
        wr(CTRL_OFFSET, 8'h11);
        settle(2);
        check(dischargeOn, 8'h01);
        wr(EDGE_OFFSET, 8'h00);
        wr(CTRL_OFFSET, 8'h0d);
        wr(EDGE_OFFSET, 8'h01);
        settle(TRIP + 6);
        check(pulse_out, 8'h00);
        check(dischargeOn, 8'h00);
        delay_trigger_in <= 1'b1;
        wait_pulse;
        check(8'(n <= 6), 8'h01);
        rd(STATUS_OFFSET, 8'((1 << PULSE_BIT) | (1 << DELAY_DONE_BIT)));
        wr(EDGE_OFFSET, 8'h00);
        settle(2);
        check(pulse_out, 8'h00);
        // comparator source: trigger held high must not end the delay
        wr(CTRL_OFFSET, 8'h11);
        wr(CTRL_OFFSET, 8'h05);
        wr(EDGE_OFFSET, 8'h01);
        wait_pulse;
        check(8'(n >= TRIP - 2 && n <= TRIP + 10), 8'h01);
        check(currentSourceOn, 8'h00);
        conclude;
    end
endmodule : tb
